// file: inc/igap_cfg.svh
`ifndef IGAP_CFG_SVH
`define IGAP_CFG_SVH
// Register byte offsets
`define IGAP_CTRL 8'h00
`define IGAP_COLBIN 8'h04
`define IGAP_ROWBIN 8'h08
`define IGAP_COLSUB 8'h0c
`define IGAP_ROWSUB 8'h10
`define IGAP_CROPCOL 8'h14
`define IGAP_CROPROW 8'h18
`define IGAP_OUTW 8'h1c
`define IGAP_OUTH 8'h20
`define IGAP_STRIDE 8'h24
`define IGAP_REDW 8'h28
`define IGAP_REDH 8'h2c
`define IGAP_TAPS 8'h30
`define IGAP_STATUS 8'h34
// Field positions
`define IGAP_CTRL_MIRH 0
`define IGAP_CTRL_MIRV 1
`define IGAP_ST_CLAMP 0
`define IGAP_ST_ZERO 1
`define IGAP_ST_EMIT 2
`define IGAP_TAPS_DIG 4
// Reset values
`define IGAP_FACTOR_RST 16'h0001
`define IGAP_OUTW_RST 16'h0010
`define IGAP_OUTH_RST 16'h0010
`define IGAP_STRIDE_RST 16'h0040
`endif

// file: inc/igap_pkg.sv
package igap_pkg;
	// Tap count coding, shared by sensor and digitizer
	typedef enum logic [3:0] {
		IGAP_TAPS_ONE = 4'h1,
		IGAP_TAPS_TWO = 4'h2,
		IGAP_TAPS_THREE = 4'h3,
		IGAP_TAPS_FOUR = 4'h4,
		IGAP_TAPS_EIGHT = 4'h8,
		IGAP_TAPS_TEN = 4'ha,
		IGAP_TAPS_DEVICE = 4'hf
	} igap_taps_t;
	typedef enum logic [3:0] {
		ST_WAIT = 4'b0001,
		ST_CAPTURE = 4'b0010,
		ST_SETUP = 4'b0100,
		ST_EMIT = 4'b1000
	} igap_state_t;
endpackage : igap_pkg

// file: logic/igap_top.sv
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "igap_cfg.svh"
module igap_top
	import igap_pkg::*;
#(
	parameter int SENSOR_W = 32,
	parameter int SENSOR_H = 24,
	parameter int PIX_W = 8,
	parameter int ACC_W = 16,
	parameter int DIM_W = 16,
	parameter int BYTES_PER_PIX = 2,
	parameter igap_taps_t SENSOR_TAPS = IGAP_TAPS_ONE,
	parameter igap_taps_t DIGITIZER_TAPS = IGAP_TAPS_ONE
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [PIX_W-1:0] pixIn,
	input wire logic pixInValid,
	input wire logic pixInFirst,
	output logic pixInReady,
	output logic [ACC_W-1:0] outPixel,
	output logic [31:0] outAddr,
	output logic outValid,
	output logic outLast,
	input wire logic outReady
);
	localparam int MEM_N = SENSOR_W * SENSOR_H;
	localparam int AW = $clog2(MEM_N);

	// Sizes the logic cannot serve; a one-cell store would leave no address bits
	if (SENSOR_W < 1 || SENSOR_H < 1 || ACC_W < PIX_W || DIM_W < 8 || MEM_N < 2
		|| SENSOR_W >= 2 ** DIM_W || SENSOR_H >= 2 ** DIM_W) begin : gBadParams
		$error("igap_top: unsupported parameters");
	end

	igap_state_t state;
	logic [DIM_W-1:0] colBin, rowBin, colSub, rowSub;
	logic [DIM_W-1:0] cropCol, cropRow, outW, outH, stride;
	logic mirH, mirV;
	logic [DIM_W-1:0] reducedW, reducedH;
	logic clampSeen, zeroSeen;
	// Bus address phase captured for the data phase
	logic wrPend;
	logic [7:0] wrAddr;
	logic busTake;
	logic [DIM_W-1:0] wv;
	logic wrHit;
	assign busTake = hsel && hready && htrans[1];
	assign wv = hwdata[DIM_W-1:0];
	assign wrHit = wrPend;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wrPend <= 1'b0;
			wrAddr <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			if (hready) begin
				wrPend <= busTake && hwrite;
				wrAddr <= haddr[7:0];
			end
		end
	end

	// Register writes; a zero factor or size is refused and flagged
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			colBin <= `IGAP_FACTOR_RST;
			rowBin <= `IGAP_FACTOR_RST;
			colSub <= `IGAP_FACTOR_RST;
			rowSub <= `IGAP_FACTOR_RST;
			cropCol <= '0;
			cropRow <= '0;
			outW <= `IGAP_OUTW_RST;
			outH <= `IGAP_OUTH_RST;
			stride <= `IGAP_STRIDE_RST;
			mirH <= 1'b0;
			mirV <= 1'b0;
		end else if (wrHit) begin
			unique case (wrAddr)
				`IGAP_CTRL: begin
					mirH <= hwdata[`IGAP_CTRL_MIRH];
					mirV <= hwdata[`IGAP_CTRL_MIRV];
				end
				`IGAP_COLBIN: if (wv != '0) colBin <= wv;
				`IGAP_ROWBIN: if (wv != '0) rowBin <= wv;
				`IGAP_COLSUB: if (wv != '0) colSub <= wv;
				`IGAP_ROWSUB: if (wv != '0) rowSub <= wv;
				`IGAP_CROPCOL: cropCol <= wv;
				`IGAP_CROPROW: cropRow <= wv;
				`IGAP_OUTW: if (wv != '0) outW <= wv;
				`IGAP_OUTH: if (wv != '0) outH <= wv;
				`IGAP_STRIDE: stride <= wv;
				default: ;
			endcase
		end
	end

	logic zeroRefused;
	assign zeroRefused = wrHit && wv == '0 && (wrAddr == `IGAP_COLBIN
		|| wrAddr == `IGAP_ROWBIN || wrAddr == `IGAP_COLSUB
		|| wrAddr == `IGAP_ROWSUB || wrAddr == `IGAP_OUTW || wrAddr == `IGAP_OUTH);

	// Read data launched in the address phase, so no wait states
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hrdata <= 32'h00000000;
		end else if (busTake && !hwrite) begin
			unique case (haddr[7:0])
				`IGAP_CTRL: hrdata <= 32'({mirV, mirH});
				`IGAP_COLBIN: hrdata <= 32'(colBin);
				`IGAP_ROWBIN: hrdata <= 32'(rowBin);
				`IGAP_COLSUB: hrdata <= 32'(colSub);
				`IGAP_ROWSUB: hrdata <= 32'(rowSub);
				`IGAP_CROPCOL: hrdata <= 32'(cropCol);
				`IGAP_CROPROW: hrdata <= 32'(cropRow);
				`IGAP_OUTW: hrdata <= 32'(outW);
				`IGAP_OUTH: hrdata <= 32'(outH);
				`IGAP_STRIDE: hrdata <= 32'(stride);
				`IGAP_REDW: hrdata <= 32'(reducedW);
				`IGAP_REDH: hrdata <= 32'(reducedH);
				`IGAP_TAPS: hrdata <= 32'({DIGITIZER_TAPS, SENSOR_TAPS});
				`IGAP_STATUS: hrdata <= 32'({state == ST_EMIT, zeroSeen, clampSeen});
				default: hrdata <= 32'h00000000;
			endcase
		end
	end

	// Reduced size: binned count, then subsampled count rounded up
	logic [DIM_W-1:0] binW, binH, calcW, calcH;
	assign binW = DIM_W'(SENSOR_W) / colBin;
	assign binH = DIM_W'(SENSOR_H) / rowBin;
	assign calcW = (binW + colSub - 1'b1) / colSub;
	assign calcH = (binH + rowSub - 1'b1) / rowSub;

	// A factor beyond the sensor still reports one pixel, never zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reducedW <= DIM_W'(1);
			reducedH <= DIM_W'(1);
		end else begin
			reducedW <= (calcW == '0) ? DIM_W'(1) : calcW;
			reducedH <= (calcH == '0) ? DIM_W'(1) : calcH;
		end
	end

	// Capture: factors and mirrors frozen at the first pixel of a frame
	logic [DIM_W-1:0] sColBin, sRowBin, sColSub, sRowSub;
	logic sMirH, sMirV;
	logic [DIM_W-1:0] inX, inY, hb, hs, vb, vs, wc, wr, capW, capH;
	logic [ACC_W-1:0] hAcc, blockSum, memOld;
	logic accept, frameStart, lineEnd, frameEnd, blockDone, colKeep, rowDone;
	logic [DIM_W-1:0] cx, cy;
	assign accept = pixInValid && pixInReady;
	assign frameStart = accept && pixInFirst;
	assign cx = frameStart ? '0 : inX;
	assign cy = frameStart ? '0 : inY;
	assign lineEnd = cx == DIM_W'(SENSOR_W - 1);
	assign frameEnd = lineEnd && cy == DIM_W'(SENSOR_H - 1);
	logic [DIM_W-1:0] fColBin, fRowBin, fColSub, fRowSub;
	assign fColBin = frameStart ? colBin : sColBin;
	assign fRowBin = frameStart ? rowBin : sRowBin;
	assign fColSub = frameStart ? colSub : sColSub;
	assign fRowSub = frameStart ? rowSub : sRowSub;
	logic [DIM_W-1:0] fHb, fHs, fVb, fVs, fWc, fWr;
	assign fHb = frameStart ? '0 : hb;
	assign fHs = frameStart ? '0 : hs;
	assign fVb = frameStart ? '0 : vb;
	assign fVs = frameStart ? '0 : vs;
	assign fWc = frameStart ? '0 : wc;
	assign fWr = frameStart ? '0 : wr;
	// Factor one makes every pixel its own block
	assign blockSum = (fHb == '0) ? ACC_W'(pixIn) : hAcc + ACC_W'(pixIn);
	assign blockDone = fHb == fColBin - 1'b1;
	assign colKeep = blockDone && fHs == '0;
	assign rowDone = lineEnd && fVb == fRowBin - 1'b1;
	logic capActive, rowKept;
	assign capActive = accept && (state == ST_CAPTURE || frameStart);
	assign rowKept = fVs == '0;

	logic [AW-1:0] capAddr;
	assign capAddr = AW'(fWr * DIM_W'(SENSOR_W) + fWc);

	// Frame store holds the reduced image, unmirrored
	logic [ACC_W-1:0] frameMem [MEM_N];
	assign memOld = frameMem[capAddr];
	always_ff @(posedge clk) begin
		// Rows of a vertical bin are summed in place
		if (capActive && colKeep && rowKept)
			frameMem[capAddr] <= (fVb == '0) ? blockSum : memOld + blockSum;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sColBin <= `IGAP_FACTOR_RST;
			sRowBin <= `IGAP_FACTOR_RST;
			sColSub <= `IGAP_FACTOR_RST;
			sRowSub <= `IGAP_FACTOR_RST;
			sMirH <= 1'b0;
			sMirV <= 1'b0;
		end else if (frameStart) begin
			sColBin <= colBin;
			sRowBin <= rowBin;
			sColSub <= colSub;
			sRowSub <= rowSub;
			sMirH <= mirH;
			sMirV <= mirV;
		end
	end

	// Raster and reduction counters; partial blocks at an edge are dropped
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			inX <= '0;
			inY <= '0;
			hb <= '0;
			hs <= '0;
			vb <= '0;
			vs <= '0;
			wc <= '0;
			wr <= '0;
			hAcc <= '0;
			capW <= '0;
			capH <= '0;
		end else if (capActive) begin
			hAcc <= blockSum;
			hb <= blockDone ? '0 : fHb + 1'b1;
			if (blockDone) begin
				hs <= (fHs == fColSub - 1'b1) ? '0 : fHs + 1'b1;
				wc <= fWc + DIM_W'(colKeep);
			end else begin
				hs <= fHs;
				wc <= fWc;
			end
			inX <= lineEnd ? '0 : cx + 1'b1;
			inY <= cy;
			vb <= fVb;
			vs <= fVs;
			wr <= fWr;
			if (lineEnd) begin
				hb <= '0;
				hs <= '0;
				wc <= '0;
				capW <= fWc + DIM_W'(colKeep);
				inY <= cy + 1'b1;
				vb <= rowDone ? '0 : fVb + 1'b1;
				if (rowDone) begin
					vs <= (fVs == fRowSub - 1'b1) ? '0 : fVs + 1'b1;
					wr <= fWr + DIM_W'(rowKept);
				end
			end
			if (frameEnd)
				capH <= fWr + DIM_W'(rowDone && rowKept);
		end
	end

	// Crop clamped into the captured image, origin at its upper left
	logic [DIM_W-1:0] effCol, effRow, effW, effH;
	logic [DIM_W-1:0] maxCol, maxRow, roomW, roomH;
	assign maxCol = (cropCol >= capW) ? capW - 1'b1 : cropCol;
	assign maxRow = (cropRow >= capH) ? capH - 1'b1 : cropRow;
	assign roomW = capW - maxCol;
	assign roomH = capH - maxRow;
	logic clampNow;
	assign clampNow = cropCol != maxCol || cropRow != maxRow
		|| outW > roomW || outH > roomH;

	// Emission counters in pixels; bytes only appear in the address
	logic [DIM_W-1:0] oc, orow;
	logic [31:0] lineBase, colOff;
	logic [DIM_W-1:0] srcCol, srcRow;
	logic [DIM_W-1:0] posCol, posRow;
	assign posCol = effCol + oc;
	assign posRow = effRow + orow;
	assign srcCol = sMirH ? capW - 1'b1 - posCol : posCol;
	assign srcRow = sMirV ? capH - 1'b1 - posRow : posRow;
	logic [AW-1:0] rdAddr;
	assign rdAddr = AW'(srcRow * DIM_W'(SENSOR_W) + srcCol);
	logic issue, lastCol, lastPix;
	assign issue = state == ST_EMIT && (!outValid || outReady);
	assign lastCol = oc == effW - 1'b1;
	assign lastPix = lastCol && orow == effH - 1'b1;

	// Sequencer; input is held off while the stored frame is sent
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_WAIT;
			pixInReady <= 1'b1;
		end else begin
			unique case (state)
				ST_WAIT: if (frameStart) state <= frameEnd ? ST_SETUP : ST_CAPTURE;
				ST_CAPTURE: if (accept && frameEnd) state <= ST_SETUP;
				ST_SETUP: state <= (capW == '0 || capH == '0) ? ST_WAIT : ST_EMIT;
				ST_EMIT: if (issue && lastPix) state <= ST_WAIT;
			endcase
			if (accept && frameEnd)
				pixInReady <= 1'b0;
			else if (state == ST_SETUP && (capW == '0 || capH == '0))
				pixInReady <= 1'b1;
			else if (issue && lastPix)
				pixInReady <= 1'b1;
		end
	end

	// Sticky flags; a new event wins over a clear in the same cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clampSeen <= 1'b0;
			zeroSeen <= 1'b0;
		end else begin
			if (state == ST_SETUP && clampNow)
				clampSeen <= 1'b1;
			else if (wrHit && wrAddr == `IGAP_STATUS && hwdata[`IGAP_ST_CLAMP])
				clampSeen <= 1'b0;
			if (zeroRefused)
				zeroSeen <= 1'b1;
			else if (wrHit && wrAddr == `IGAP_STATUS && hwdata[`IGAP_ST_ZERO])
				zeroSeen <= 1'b0;
		end
	end

	// Output stage: one pixel per free slot, address from line base
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			effCol <= '0;
			effRow <= '0;
			effW <= DIM_W'(1);
			effH <= DIM_W'(1);
			oc <= '0;
			orow <= '0;
			lineBase <= 32'h00000000;
			colOff <= 32'h00000000;
			outPixel <= '0;
			outAddr <= 32'h00000000;
			outValid <= 1'b0;
			outLast <= 1'b0;
		end else if (state == ST_SETUP) begin
			effCol <= maxCol;
			effRow <= maxRow;
			effW <= (outW > roomW) ? roomW : outW;
			effH <= (outH > roomH) ? roomH : outH;
			oc <= '0;
			orow <= '0;
			lineBase <= 32'h00000000;
			colOff <= 32'h00000000;
		end else if (issue) begin
			outPixel <= frameMem[rdAddr];
			outAddr <= lineBase + colOff;
			outValid <= 1'b1;
			outLast <= lastPix;
			if (lastCol) begin
				oc <= '0;
				orow <= orow + 1'b1;
				colOff <= 32'h00000000;
				lineBase <= lineBase + 32'(stride);
			end else begin
				oc <= oc + 1'b1;
				colOff <= colOff + 32'(BYTES_PER_PIX);
			end
		end else if (outReady) begin
			outValid <= 1'b0;
			outLast <= 1'b0;
		end
	end
endmodule : igap_top

// file: test/igap_top_asserts.sv
`timescale 1ns/1ps
`include "igap_cfg.svh"
module igap_chk
	import igap_pkg::*;
#(
	parameter int ACC_W = 16,
	parameter igap_taps_t SENSOR_TAPS = IGAP_TAPS_ONE,
	parameter igap_taps_t DIGITIZER_TAPS = IGAP_TAPS_ONE
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic pixInReady,
	input wire logic [ACC_W-1:0] outPixel,
	input wire logic [31:0] outAddr,
	input wire logic outValid,
	input wire logic outLast,
	input wire logic outReady
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!resetn);
	// Read taken at this edge; its data stands in the next cycle
	wire rdTaken = hsel && hready && htrans[1] && !hwrite;
	// Output beats and frame boundaries
	property p_outHold;
		outValid && !outReady |=> outValid && $stable(outPixel) && $stable(outAddr) && $stable(outLast);
	endproperty
	a_outHold: assert property (p_outHold) else $error("stalled output moved");
	property p_emitAfterCapture;
		outValid && !outLast |-> !pixInReady;
	endproperty
	a_emitAfterCapture: assert property (p_emitAfterCapture) else $error("emit overlaps capture");
	property p_firstAddr;
		$fell(pixInReady) |-> ##[1:2] (outValid && outAddr == 32'h0);
	endproperty
	a_firstAddr: assert property (p_firstAddr) else $error("first beat not at origin");
	property p_frameEnd;
		outValid && outReady && outLast |=> ##[0:1] (pixInReady && !outValid);
	endproperty
	a_frameEnd: assert property (p_frameEnd) else $error("beats after last");
	// Read-only reports
	property p_sensTaps;
		rdTaken && haddr[7:0] == `IGAP_TAPS |=> hrdata[3:0] == SENSOR_TAPS;
	endproperty
	a_sensTaps: assert property (p_sensTaps) else $error("sensor taps wrong");
	property p_digTaps;
		rdTaken && haddr[7:0] == `IGAP_TAPS |=> hrdata[7:4] == DIGITIZER_TAPS;
	endproperty
	a_digTaps: assert property (p_digTaps) else $error("digitizer taps wrong");
	property p_redWidth;
		rdTaken && haddr[7:0] == `IGAP_REDW |=> hrdata[15:0] != 16'h0;
	endproperty
	a_redWidth: assert property (p_redWidth) else $error("reduced width zero");
	property p_redHeight;
		rdTaken && haddr[7:0] == `IGAP_REDH |=> hrdata[15:0] != 16'h0;
	endproperty
	a_redHeight: assert property (p_redHeight) else $error("reduced height zero");
endmodule : igap_chk

// file: test/igap_sensor_model.sv
`timescale 1ns/1ps
module igap_sensor_model #(
	parameter int W = 8,
	parameter int H = 4
) (
	input wire logic clk,
	input wire logic go,
	input wire logic slow,
	input wire logic pixInReady,
	output logic [7:0] pixIn,
	output logic pixInValid,
	output logic pixInFirst,
	output logic outReady
);
	logic [7:0] val = 8'h0;
	initial begin
		pixIn = 8'h0;
		pixInValid = 1'b0;
		pixInFirst = 1'b0;
		outReady = 1'b1;
	end
	// Receiver stalls every other cycle when slow, so held outputs get exercised
	always @(posedge clk) outReady <= slow ? ~outReady : 1'b1;
	// Sensor: one raster per go pulse, value 16*row+col; idle line shows the inverse
	always @(posedge clk) if (go) begin
		for (int y = 0; y < H; y++) for (int x = 0; x < W; x++) begin
			val = 8'(y * 16 + x);
			pixIn <= val;
			pixInFirst <= (x == 0 && y == 0);
			pixInValid <= 1'b1;
			do @(posedge clk); while (pixInReady !== 1'b1);
			if (slow) begin
				pixInValid <= 1'b0;
				pixIn <= ~val;
				@(posedge clk);
			end
		end
		pixInValid <= 1'b0;
		pixInFirst <= 1'b0;
		pixIn <= ~val;
	end
endmodule : igap_sensor_model

// file: test/tb.sv
`timescale 1ns/1ps
`include "igap_cfg.svh"
module tb
	import igap_pkg::*;
;
	localparam int SW = 8;
	localparam int SH = 4;
	logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, slow = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, outAddr;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, pixInValid, pixInFirst, pixInReady, outValid, outLast, outReady;
	logic [7:0] pixIn;
	logic [15:0] outPixel;
	logic [15:0] gotPix[$];
	logic [31:0] gotAddr[$];
	logic gotLast[$];
	int badCount = 0, samplesChecked = 0;
	logic [7:0] ofs[10] = '{`IGAP_CTRL, `IGAP_COLBIN, `IGAP_ROWBIN, `IGAP_COLSUB,
		`IGAP_ROWSUB, `IGAP_CROPCOL, `IGAP_CROPROW, `IGAP_OUTW, `IGAP_OUTH, `IGAP_STRIDE};
	// 125 MHz clock
	always #4 clk = ~clk;
	igap_top #(.SENSOR_W(SW), .SENSOR_H(SH), .SENSOR_TAPS(IGAP_TAPS_FOUR),
		.DIGITIZER_TAPS(IGAP_TAPS_TEN)) igap_top_inst (.clk(clk), .resetn(resetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .pixIn(pixIn), .pixInValid(pixInValid), .pixInFirst(pixInFirst),
		.pixInReady(pixInReady), .outPixel(outPixel), .outAddr(outAddr),
		.outValid(outValid), .outLast(outLast), .outReady(outReady));
	igap_sensor_model #(.W(SW), .H(SH)) igap_sensor_model_inst (.clk(clk), .go(go),
		.slow(slow), .pixInReady(pixInReady), .pixIn(pixIn), .pixInValid(pixInValid),
		.pixInFirst(pixInFirst), .outReady(outReady));
	// Collect accepted beats at the falling edge, where every flop has settled
	always @(negedge clk) if (outValid === 1'b1 && outReady === 1'b1) begin
		gotPix.push_back(outPixel);
		gotAddr.push_back(outAddr);
		gotLast.push_back(outLast);
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			badCount++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Single word transfer; latency is never assumed, hready is awaited in both phases
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n = 0;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1 && n++ < 100);
		if (hreadyout !== 1'b1) badCount++;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1 && n++ < 200);
		if (hreadyout !== 1'b1) badCount++;
		rd = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		check(what, r, exp);
	endtask : rdchk
	task automatic testReset();
		rdchk("control", `IGAP_CTRL, 32'h0);
		rdchk("column combine", `IGAP_COLBIN, 32'h1);
		rdchk("output width", `IGAP_OUTW, 32'h10);
		rdchk("stride", `IGAP_STRIDE, 32'h40);
		rdchk("reduced width", `IGAP_REDW, 32'(SW));
		rdchk("taps", `IGAP_TAPS, {24'h0, IGAP_TAPS_TEN, IGAP_TAPS_FOUR});
		rdchk("unmapped", 8'h40, 32'h0);
		check("response", hresp, 1'b0);
		check("ready", hreadyout, 1'b1);
		$display("test reset done");
	endtask : testReset
	// A zero factor is refused and flagged; the flag clears by writing one
	task automatic testZero();
		wr(`IGAP_COLSUB, 32'h0);
		rdchk("column subsample", `IGAP_COLSUB, 32'h1);
		rdchk("status", `IGAP_STATUS, 32'h2);
		wr(`IGAP_STATUS, 32'h2);
		rdchk("status", `IGAP_STATUS, 32'h0);
		$display("test zero done");
	endtask : testZero
	// Configure, stream one frame and compare every emitted beat against the model
	task automatic frame(input string name, input int cb, rb, cs, rs, mh, mv, cc, cr, w, h,
		st, input logic sl);
		int v[10];
		int rw, rh, ew, eh, n, k, sc, sr, e;
		v = '{mv * 2 + mh, cb, rb, cs, rs, cc, cr, w, h, st};
		for (int i = 0; i < 10; i++) wr(ofs[i], 32'(v[i]));
		rw = (SW / cb + cs - 1) / cs;
		rh = (SH / rb + rs - 1) / rs;
		ew = (w < rw - cc) ? w : rw - cc;
		eh = (h < rh - cr) ? h : rh - cr;
		@(posedge clk);
		rdchk("reduced width", `IGAP_REDW, 32'(rw));
		rdchk("reduced height", `IGAP_REDH, 32'(rh));
		gotPix.delete();
		gotAddr.delete();
		gotLast.delete();
		slow <= sl;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		while (gotPix.size() < ew * eh && n++ < 4000) @(posedge clk);
		repeat (6) @(posedge clk);
		check("beat count", gotPix.size(), ew * eh);
		for (int l = 0; l < eh; l++) for (int c = 0; c < ew; c++) begin
			k = l * ew + c;
			sc = mh ? rw - 1 - (cc + c) : cc + c;
			sr = mv ? rh - 1 - (cr + l) : cr + l;
			e = 0;
			for (int i = 0; i < rb; i++) for (int j = 0; j < cb; j++)
				e += (sr * rs * rb + i) * 16 + sc * cs * cb + j;
			check("pixel", gotPix[k], e);
			check("address", gotAddr[k], l * st + c * 2);
			check("last", gotLast[k], k == ew * eh - 1);
		end
		rdchk("status", `IGAP_STATUS, (ew < w || eh < h) ? 32'h1 : 32'h0);
		wr(`IGAP_STATUS, 32'h3);
		$display("test %s done", name);
	endtask : frame
	// Straight pass, every factor one
	task automatic testPlain();
		frame("plain", 1, 1, 1, 1, 0, 0, 0, 0, 8, 4, 20, 1'b0);
	endtask : testPlain
	// Binning both ways plus column subsampling, with a stalling receiver
	task automatic testCombine();
		frame("combine", 2, 2, 2, 1, 0, 0, 0, 0, 2, 2, 8, 1'b1);
	endtask : testCombine
	// Both mirrors with an offset crop
	task automatic testMirror();
		frame("mirror", 1, 1, 1, 1, 1, 1, 1, 1, 5, 2, 16, 1'b1);
	endtask : testMirror
	// Oversized crop on a subsampled image gets clamped
	task automatic testClamp();
		frame("clamp", 1, 1, 3, 2, 0, 0, 0, 0, 8, 4, 12, 1'b0);
	endtask : testClamp
	task automatic testDone();
		$display("checks %0d mismatches %0d", samplesChecked, badCount);
		if (badCount == 0 && samplesChecked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : testDone
	// Main sequence; reset held for three cycles
	initial begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		testReset();
		testZero();
		testPlain();
		testCombine();
		testMirror();
		testClamp();
		testDone();
	end
	// Watchdog: the whole run needs a few thousand cycles at most
	initial begin
		repeat (20000) @(posedge clk);
		badCount++;
		testDone();
	end
endmodule : tb
bind igap_top igap_chk #(.ACC_W(ACC_W), .SENSOR_TAPS(SENSOR_TAPS),
	.DIGITIZER_TAPS(DIGITIZER_TAPS)) igap_chk_inst (.clk(clk), .resetn(resetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.pixInReady(pixInReady), .outPixel(outPixel), .outAddr(outAddr), .outValid(outValid),
	.outLast(outLast), .outReady(outReady));
